// file: logic/rthri_pkg.sv
// Operation
// - Write with all selects low loads control byte
// - Write with address bit high does master reset
// - Read with address low drives 16 status bits
// - Control bits 0/1 enable channel A/B inputs
// - Control bit 2 sets terminal flag bit
// - Control bit 3 sets busy, blocks memory
// - Control bit 4 sets subsystem flag bit
// - Control bit 5 picks self-test channel
// - Control bit 6 enters self-test, suspends operation
// - Control bit 7 sets service request; upper ignored
// - Status 4:0 code, bit 5 subaddress flag
// - Status bit 6 shows command channel A
// - Status bits 7/8 show channel B/A enabled
// - Status bit 9 terminal flag enable, inhibitable
// - Status bit 10 follows system busy bit
// - Status bit 11 shows self-test mode
// - Status bit 12 parity error disables inputs
// - Status bit 13 sticky message error
// - Status bit 14 sticky valid message
// - Status bit 15 is NAND of activity
// - Last-command register keeps received command word
// - Last-command low 11 bits plus status copies
package rthri_pkg;
	// Bus widths
	localparam int DATA_W = 16;
	localparam int CTRL_W = 8;
	// Clock and host setup figure
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CTRL_SETUP_NS = 50;
	localparam int CTRL_SETUP_CYC =
		(CTRL_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Control register fields
	localparam int CTL_CHA_EN = 0;
	localparam int CTL_CHB_EN = 1;
	localparam int CTL_TFLAG = 2;
	localparam int CTL_BUSY = 3;
	localparam int CTL_SUBSYS = 4;
	localparam int CTL_ST_CH = 5;
	localparam int CTL_ST_EN = 6;
	localparam int CTL_SRVRQ = 7;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
	// Status register fields
	localparam int ST_CODE_LSB = 0;
	localparam int ST_CODE_MSB = 4;
	localparam int ST_MODE_SUBADDR_CODE = 5;
	localparam int ST_CHAN_A = 6;
	localparam int ST_CHB_EN = 7;
	localparam int ST_CHA_EN = 8;
	localparam int ST_TF_EN = 9;
	localparam int ST_BUSY = 10;
	localparam int ST_SELFTEST = 11;
	localparam int ST_PARITY = 12;
	localparam int ST_MSG_ERR = 13;
	localparam int ST_VALID = 14;
	localparam int ST_ACTIVE = 15;
	// Last-command fields and reset value
	localparam int LC_CMD_MSB = 10;
	localparam int LC_BUSY = 11;
	localparam int LC_SELFTEST = 12;
	localparam int LC_TF_EN = 13;
	localparam int LC_CHAN_A = 14;
	localparam int LC_ILLEGAL = 15;
	localparam logic [DATA_W-1:0] LAST_CMD_RESET = 16'hE7FF;
	// Command word subaddress field
	localparam int CW_SA_LSB = 5;
	localparam int CW_SA_MSB = 9;
	localparam logic [4:0] SA_MODE_LO = 5'h00;
	localparam logic [4:0] SA_MODE_HI = 5'h1F;
	// Host cycle tracking states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_READ = 2'b10
	} rthri_bus_e;
endpackage

// file: logic/rthri_sticky_flag.sv
`timescale 1ns/1ps
// Sticky status flag, cleared after a completed read
module rthri_sticky_flag (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic clr_i,
	input wire logic set_i,
	input wire logic read_done_i,
	input wire logic hold_i,
	// Flag
	output logic flag_o
);
	logic flag_reg;
	logic flag_next;
	logic seen_reg; // Flag has been read since last set
	logic seen_next;

	// Next flag value; clear wins, then a new event wins over a read
	always_comb begin
		flag_next = flag_reg;
		seen_next = seen_reg;
		if (clr_i) begin
			flag_next = 1'b0;
			seen_next = 1'b0;
		end else if (set_i) begin
			flag_next = 1'b1;
			seen_next = 1'b0;
		end else if (flag_reg) begin
			// Read marks it seen; clear once condition is gone
			if (read_done_i || seen_reg) begin
				if (!hold_i) begin
					flag_next = 1'b0;
					seen_next = 1'b0;
				end else begin
					seen_next = 1'b1;
				end
			end
		end
	end

	// Registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_reg <= 1'b0;
			seen_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
			seen_reg <= seen_next;
		end
	end

	assign flag_o = flag_reg;
endmodule

// file: logic/rt_host_register_interface.sv
`timescale 1ns/1ps
// Host register port of the remote terminal interface
module rt_host_register_interface (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RESET_N_I,
	// Host register port
	input wire logic CS_N_I,
	input wire logic REG_SEL_N_I,
	input wire logic RD_WR_N_I,
	input wire logic ADDR0_I,
	input wire logic [rthri_pkg::DATA_W-1:0] DATA_I,
	output logic [rthri_pkg::DATA_W-1:0] DATA_O,
	output logic DATA_OE_O,
	// Events from the terminal core
	input wire logic COMMAND_STROBE_N_I,
	input wire logic CMD_STORE_I,
	input wire logic [rthri_pkg::DATA_W-1:0] CMD_WORD_I,
	input wire logic CMD_CHAN_A_I,
	input wire logic CMD_ILLEGAL_I,
	input wire logic MSG_ERROR_I,
	input wire logic VALID_MSG_I,
	input wire logic INHIBIT_TF_I,
	input wire logic OVERRIDE_TF_I,
	input wire logic TA_LOAD_I,
	input wire logic TA_PARITY_OK_I,
	input wire logic TRANSMIT_ACTIVE_N_I,
	input wire logic RECEIVE_ACTIVE_N_I,
	// Control outputs to the terminal core
	output logic MASTER_RESET_O,
	output logic CHAN_A_ENABLE_O,
	output logic CHAN_B_ENABLE_O,
	output logic MEM_ACCESS_INHIBIT_O,
	output logic SELFTEST_EN_O,
	output logic SELFTEST_CHANNEL_SEL_O,
	output logic PARITY_MSG_ERROR_O,
	// Outgoing status word flags
	output logic TERMINAL_FLAG_BIT_O,
	output logic SUBSYSTEM_BUSY_BIT_O,
	output logic SERVICE_REQUEST_BIT_O,
	// Last-command register
	output logic [rthri_pkg::DATA_W-1:0] LAST_CMD_O
);
	import rthri_pkg::*;

	// True when a command word carries a mode code
	function automatic logic is_mode_code(input logic [DATA_W-1:0] cw);
		logic [4:0] sa;
		sa = cw[CW_SA_MSB:CW_SA_LSB];
		is_mode_code = (sa == SA_MODE_LO) || (sa == SA_MODE_HI);
	endfunction

	// Host cycle decode
	logic reg_access; // Chip and register select both low
	logic wr_cond; // Write cycle present
	logic rd_cond; // Status read cycle present
	logic read_done; // Status read just ended
	logic strobe_rise; // Command strobe rising edge
	logic msg_err_cond; // Any message error condition
	logic msg_err_flag; // Sticky message error
	logic valid_flag; // Sticky valid message
	logic [DATA_W-1:0] status_now; // Live status register image

	// State and next values
	rthri_bus_e bus_reg;
	rthri_bus_e bus_next;
	logic [CTRL_W-1:0] ctrl_reg;
	logic [CTRL_W-1:0] ctrl_next;
	logic [4:0] code_reg; // Mode code or subaddress
	logic [4:0] code_next;
	logic sa_flag_reg; // Code holds a subaddress
	logic sa_flag_next;
	logic chan_a_reg; // Last command on channel A
	logic chan_a_next;
	logic tf_en_reg; // Terminal flag still enabled
	logic tf_en_next;
	logic parity_reg; // Terminal address parity bad
	logic parity_next;
	logic strobe_prev_reg;
	logic err_prev_reg; // Error condition one cycle ago
	logic err_rise; // Error condition just appeared
	logic mreset_reg;
	logic mreset_next;
	logic [DATA_W-1:0] dout_reg;
	logic [DATA_W-1:0] dout_next;
	logic doe_reg;
	logic doe_next;
	logic cha_en_reg;
	logic chb_en_reg;
	logic busy_out_reg;
	logic st_en_reg;
	logic st_ch_reg;
	logic perr_out_reg;
	logic tf_bit_reg;
	logic tf_bit_next;
	logic subsystem_busy_bit_bit_reg;
	logic subsystem_busy_bit_bit_next;
	logic srq_bit_reg;
	logic srq_bit_next;
	logic [DATA_W-1:0] last_reg;
	logic [DATA_W-1:0] last_next;

	// Cycle qualifiers from the select lines
	assign reg_access = !CS_N_I && !REG_SEL_N_I;
	assign wr_cond = reg_access && !RD_WR_N_I;
	assign rd_cond = reg_access && RD_WR_N_I && !ADDR0_I;
	assign read_done = (bus_reg == BUS_READ) && !rd_cond;
	assign strobe_rise = COMMAND_STROBE_N_I && !strobe_prev_reg;
	assign msg_err_cond = MSG_ERROR_I || parity_reg;
	// Only a fresh error restarts the flag, so a read during it counts
	assign err_rise = msg_err_cond && !err_prev_reg;

	// Status register image
	always_comb begin
		status_now = '0;
		status_now[ST_CODE_MSB:ST_CODE_LSB] = code_reg;
		status_now[ST_MODE_SUBADDR_CODE] = sa_flag_reg;
		status_now[ST_CHAN_A] = chan_a_reg;
		status_now[ST_CHB_EN] = ctrl_reg[CTL_CHB_EN];
		status_now[ST_CHA_EN] = ctrl_reg[CTL_CHA_EN];
		status_now[ST_TF_EN] = tf_en_reg;
		status_now[ST_BUSY] = ctrl_reg[CTL_BUSY];
		status_now[ST_SELFTEST] = ctrl_reg[CTL_ST_EN];
		status_now[ST_PARITY] = parity_reg;
		status_now[ST_MSG_ERR] = msg_err_flag;
		status_now[ST_VALID] = valid_flag;
		// Active when either low-true activity line is low
		status_now[ST_ACTIVE] =
			!(TRANSMIT_ACTIVE_N_I && RECEIVE_ACTIVE_N_I);
	end

	// Sticky message error, held while the condition lasts
	// Read end only counts if the host was shown the set bit
	rthri_sticky_flag u_msg_err (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RESET_N_I),
		.clr_i(mreset_reg),
		.set_i(err_rise),
		.read_done_i(read_done && dout_reg[ST_MSG_ERR]),
		.hold_i(msg_err_cond),
		.flag_o(msg_err_flag)
	);

	// Sticky valid message
	rthri_sticky_flag u_valid (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RESET_N_I),
		.clr_i(mreset_reg),
		.set_i(VALID_MSG_I),
		.read_done_i(read_done && dout_reg[ST_VALID]),
		.hold_i(1'b0),
		.flag_o(valid_flag)
	);

	// Next values for host cycle, control and status state
	always_comb begin
		bus_next = bus_reg;
		ctrl_next = ctrl_reg;
		code_next = code_reg;
		sa_flag_next = sa_flag_reg;
		chan_a_next = chan_a_reg;
		tf_en_next = tf_en_reg;
		parity_next = parity_reg;
		mreset_next = 1'b0;
		last_next = last_reg;
		tf_bit_next = tf_bit_reg;
		subsystem_busy_bit_bit_next = subsystem_busy_bit_bit_reg;
		srq_bit_next = srq_bit_reg;
		dout_next = dout_reg;
		doe_next = rd_cond;
		if (rd_cond) begin
			dout_next = status_now;
		end
		// Host cycle tracking: one action per select assertion
		case (bus_reg)
			BUS_IDLE: begin
				if (wr_cond) begin
					bus_next = BUS_WRITE;
					if (ADDR0_I) begin
						mreset_next = 1'b1;
					end else begin
						// Upper data byte is ignored
						ctrl_next = DATA_I[CTRL_W-1:0];
					end
				end else if (rd_cond) begin
					bus_next = BUS_READ;
				end
			end
			BUS_WRITE: begin
				if (!reg_access) begin
					bus_next = BUS_IDLE;
				end
			end
			BUS_READ: begin
				// Leaving read completes it; shown sticky bits clear once their condition is gone
				if (!rd_cond) begin
					bus_next = BUS_IDLE;
				end
			end
			default: begin
				bus_next = BUS_IDLE;
			end
		endcase
		// Command decode results
		if (CMD_STORE_I) begin
			sa_flag_next = !is_mode_code(CMD_WORD_I);
			if (is_mode_code(CMD_WORD_I)) begin
				code_next = CMD_WORD_I[4:0];
			end else begin
				code_next = CMD_WORD_I[CW_SA_MSB:CW_SA_LSB];
			end
			chan_a_next = CMD_CHAN_A_I;
			// Last command with status copies
			last_next[LC_CMD_MSB:0] = CMD_WORD_I[LC_CMD_MSB:0];
			last_next[LC_BUSY] = ctrl_reg[CTL_BUSY];
			last_next[LC_SELFTEST] = ctrl_reg[CTL_ST_EN];
			last_next[LC_TF_EN] = tf_en_reg;
			last_next[LC_CHAN_A] = CMD_CHAN_A_I;
			last_next[LC_ILLEGAL] = CMD_ILLEGAL_I;
		end
		// Inhibit wins over override in the same cycle
		if (INHIBIT_TF_I) begin
			tf_en_next = 1'b0;
		end else if (OVERRIDE_TF_I) begin
			tf_en_next = 1'b1;
		end
		// Parity flag follows each address latch reload
		if (TA_LOAD_I) begin
			parity_next = !TA_PARITY_OK_I;
		end
		// Status word flags latch at command strobe rise
		if (strobe_rise) begin
			tf_bit_next = ctrl_reg[CTL_TFLAG] && tf_en_reg;
			subsystem_busy_bit_bit_next = ctrl_reg[CTL_SUBSYS];
			srq_bit_next = ctrl_reg[CTL_SRVRQ];
		end
		// Master reset returns control, status and last-command state to reset values
		if (mreset_reg) begin
			ctrl_next = CTRL_RESET;
			code_next = '0;
			sa_flag_next = 1'b0;
			chan_a_next = 1'b1;
			tf_en_next = 1'b1;
			parity_next = 1'b0;
			last_next = LAST_CMD_RESET;
			tf_bit_next = 1'b0;
			subsystem_busy_bit_bit_next = 1'b0;
			srq_bit_next = 1'b0;
		end
	end

	// State registers and registered outputs
	always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			bus_reg <= BUS_IDLE;
			ctrl_reg <= CTRL_RESET;
			code_reg <= '0;
			sa_flag_reg <= 1'b0;
			chan_a_reg <= 1'b1;
			tf_en_reg <= 1'b1;
			parity_reg <= 1'b0;
			strobe_prev_reg <= 1'b1;
			err_prev_reg <= 1'b0;
			mreset_reg <= 1'b0;
			dout_reg <= '0;
			doe_reg <= 1'b0;
			cha_en_reg <= 1'b0;
			chb_en_reg <= 1'b0;
			busy_out_reg <= 1'b0;
			st_en_reg <= 1'b0;
			st_ch_reg <= 1'b0;
			perr_out_reg <= 1'b0;
			tf_bit_reg <= 1'b0;
			subsystem_busy_bit_bit_reg <= 1'b0;
			srq_bit_reg <= 1'b0;
			last_reg <= LAST_CMD_RESET;
		end else begin
			bus_reg <= bus_next;
			ctrl_reg <= ctrl_next;
			code_reg <= code_next;
			sa_flag_reg <= sa_flag_next;
			chan_a_reg <= chan_a_next;
			tf_en_reg <= tf_en_next;
			parity_reg <= parity_next;
			strobe_prev_reg <= COMMAND_STROBE_N_I;
			err_prev_reg <= msg_err_cond;
			mreset_reg <= mreset_next;
			dout_reg <= dout_next;
			doe_reg <= doe_next;
			// Inputs blocked by bad parity or self-test
			cha_en_reg <= ctrl_reg[CTL_CHA_EN] && !parity_reg &&
				!ctrl_reg[CTL_ST_EN];
			chb_en_reg <= ctrl_reg[CTL_CHB_EN] && !parity_reg &&
				!ctrl_reg[CTL_ST_EN];
			busy_out_reg <= ctrl_reg[CTL_BUSY];
			st_en_reg <= ctrl_reg[CTL_ST_EN];
			st_ch_reg <= ctrl_reg[CTL_ST_CH];
			perr_out_reg <= parity_reg;
			tf_bit_reg <= tf_bit_next;
			subsystem_busy_bit_bit_reg <= subsystem_busy_bit_bit_next;
			srq_bit_reg <= srq_bit_next;
			last_reg <= last_next;
		end
	end

	// Output drive
	assign DATA_O = dout_reg;
	assign DATA_OE_O = doe_reg;
	assign MASTER_RESET_O = mreset_reg;
	assign CHAN_A_ENABLE_O = cha_en_reg;
	assign CHAN_B_ENABLE_O = chb_en_reg;
	assign MEM_ACCESS_INHIBIT_O = busy_out_reg;
	assign SELFTEST_EN_O = st_en_reg;
	assign SELFTEST_CHANNEL_SEL_O = st_ch_reg;
	assign PARITY_MSG_ERROR_O = perr_out_reg;
	assign TERMINAL_FLAG_BIT_O = tf_bit_reg;
	assign SUBSYSTEM_BUSY_BIT_O = subsystem_busy_bit_bit_reg;
	assign SERVICE_REQUEST_BIT_O = srq_bit_reg;
	assign LAST_CMD_O = last_reg;

	// Checks
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESET_N_I);

	ctrl_write_a: assert property (
		bus_reg == BUS_IDLE && wr_cond && !ADDR0_I && !mreset_reg
		|=> ctrl_reg == $past(DATA_I[CTRL_W-1:0]) && !MASTER_RESET_O
	) else $error("control write not loaded");
	master_reset_a: assert property (
		bus_reg == BUS_IDLE && wr_cond && ADDR0_I
		|=> MASTER_RESET_O ##1 ctrl_reg == CTRL_RESET && tf_en_reg
	) else $error("master reset not performed");
	status_read_a: assert property (
		rd_cond |=> DATA_OE_O && DATA_O == $past(status_now)
	) else $error("status read not driven");
	chan_gate_a: assert property (
		parity_reg [*2] |-> ##1 !CHAN_A_ENABLE_O && !CHAN_B_ENABLE_O
	) else $error("inputs enabled during parity error");
	tflag_latch_a: assert property (
		strobe_rise && !mreset_reg
		|=> TERMINAL_FLAG_BIT_O == $past(ctrl_reg[CTL_TFLAG] && tf_en_reg)
	) else $error("terminal flag not latched");
	busy_out_a: assert property (
		$rose(ctrl_reg[CTL_BUSY]) |=> MEM_ACCESS_INHIBIT_O &&
			status_now[ST_BUSY]
	) else $error("busy not reflected");
	selftest_a: assert property (
		$rose(ctrl_reg[CTL_ST_EN]) |=> SELFTEST_EN_O && !CHAN_A_ENABLE_O
	) else $error("self-test entry wrong");
	valid_set_a: assert property (
		VALID_MSG_I && !mreset_reg |=> valid_flag ##1
			(valid_flag || $past(read_done) || $past(mreset_reg))
	) else $error("valid message lost");
	merr_hold_a: assert property (
		msg_err_flag && msg_err_cond && !mreset_reg |=> msg_err_flag
	) else $error("message error cleared early");
	last_cmd_a: assert property (
		CMD_STORE_I && !mreset_reg
		|=> LAST_CMD_O[LC_CMD_MSB:0] == $past(CMD_WORD_I[LC_CMD_MSB:0])
	) else $error("last command not stored");
	tf_inhibit_a: assert property (
		INHIBIT_TF_I && !mreset_reg |=> !tf_en_reg ##1
			!($past(strobe_rise) && TERMINAL_FLAG_BIT_O)
	) else $error("terminal flag not inhibited");

	write_c: cover property (bus_reg == BUS_IDLE && wr_cond && !ADDR0_I);
	reset_c: cover property (MASTER_RESET_O);
	read_clr_c: cover property (valid_flag ##1 read_done ##1 !valid_flag);
	strobe_c: cover property (strobe_rise && ctrl_reg[CTL_TFLAG]);
endmodule

// file: verification/rthri_host_model.sv
`timescale 1ns/1ps
// Host processor driving the register select lines
module rthri_host_model (
	// Clock
	input wire logic clk_i,
	// Host register port
	output logic cs_n_o,
	output logic reg_sel_n_o,
	output logic rd_wr_n_o,
	output logic addr0_o,
	output logic [rthri_pkg::DATA_W-1:0] data_o,
	input wire logic [rthri_pkg::DATA_W-1:0] data_i,
	input wire logic data_oe_i
);
	import rthri_pkg::*;
	// Bus idle with selects high
	initial begin
		cs_n_o = 1'b1;
		reg_sel_n_o = 1'b1;
		rd_wr_n_o = 1'b1;
		addr0_o = 1'b0;
		data_o = 16'h0000;
	end
	// Write cycle held over one clock edge
	task automatic write(input logic a0, input logic [DATA_W-1:0] d);
		@(negedge clk_i);
		cs_n_o = 1'b0;
		reg_sel_n_o = 1'b0;
		rd_wr_n_o = 1'b0;
		addr0_o = a0;
		data_o = d;
		@(negedge clk_i);
		cs_n_o = 1'b1;
		reg_sel_n_o = 1'b1;
		rd_wr_n_o = 1'b1;
		// Released bus shows the inverse, never a stale copy
		data_o = ~d;
		@(negedge clk_i);
	endtask
	// Read cycle, data taken once the port drives
	task automatic read(input logic a0, output logic [DATA_W-1:0] d,
		output logic oe);
		@(negedge clk_i);
		cs_n_o = 1'b0;
		reg_sel_n_o = 1'b0;
		rd_wr_n_o = 1'b1;
		addr0_o = a0;
		repeat (2) @(negedge clk_i);
		d = data_i;
		oe = data_oe_i;
		cs_n_o = 1'b1;
		reg_sel_n_o = 1'b1;
		// Let the read end and sticky bits settle
		repeat (2) @(negedge clk_i);
	endtask
endmodule

// file: verification/rt_host_register_interface_tb.sv
`timescale 1ns/1ps
// Bench for the host register port
module rt_host_register_interface_tb;
	import rthri_pkg::*;
	// Clock and reset
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	// Host bus
	logic cs_n, reg_sel_n, rd_wr_n, addr0, data_oe, rd_oe;
	logic [DATA_W-1:0] host_data, data_out, last_cmd, rd_val;
	// Core side inputs
	logic strobe_n = 1'b1;
	logic cmd_store = 1'b0;
	logic [DATA_W-1:0] cmd_word = 16'h0000;
	logic cmd_a = 1'b1;
	logic cmd_ill = 1'b0;
	logic msg_err = 1'b0;
	logic valid_msg = 1'b0;
	logic inh_tf = 1'b0;
	logic ovr_tf = 1'b0;
	logic ta_load = 1'b0;
	logic ta_ok = 1'b1;
	logic tx_n = 1'b1;
	logic rx_n = 1'b1;
	// Core side outputs
	logic mreset, cha_en, chb_en, mem_inh, st_en, st_ch, par_err;
	logic tf_bit, subsystem_busy_bit_bit, srv_bit;
	// Counters and table of control byte, status, derived outputs
	int err_count = 0;
	int checks_done = 0;
	int mr_cnt = 0;
	logic [36:0] rows [7];

	// Clock of 5 ns period
	initial begin
		forever #2.5 clk = ~clk;
	end

	rthri_host_model u_rthri_host_model (.clk_i(clk), .cs_n_o(cs_n),
		.reg_sel_n_o(reg_sel_n), .rd_wr_n_o(rd_wr_n), .addr0_o(addr0),
		.data_o(host_data), .data_i(data_out), .data_oe_i(data_oe));

	rt_host_register_interface u_rt_host_register_interface (
		.CLK_SYS_I(clk), .RESET_N_I(rst_n), .CS_N_I(cs_n),
		.REG_SEL_N_I(reg_sel_n), .RD_WR_N_I(rd_wr_n), .ADDR0_I(addr0),
		.DATA_I(host_data), .DATA_O(data_out), .DATA_OE_O(data_oe),
		.COMMAND_STROBE_N_I(strobe_n), .CMD_STORE_I(cmd_store),
		.CMD_WORD_I(cmd_word), .CMD_CHAN_A_I(cmd_a),
		.CMD_ILLEGAL_I(cmd_ill), .MSG_ERROR_I(msg_err),
		.VALID_MSG_I(valid_msg), .INHIBIT_TF_I(inh_tf),
		.OVERRIDE_TF_I(ovr_tf), .TA_LOAD_I(ta_load),
		.TA_PARITY_OK_I(ta_ok), .TRANSMIT_ACTIVE_N_I(tx_n),
		.RECEIVE_ACTIVE_N_I(rx_n), .MASTER_RESET_O(mreset),
		.CHAN_A_ENABLE_O(cha_en), .CHAN_B_ENABLE_O(chb_en),
		.MEM_ACCESS_INHIBIT_O(mem_inh), .SELFTEST_EN_O(st_en),
		.SELFTEST_CHANNEL_SEL_O(st_ch), .PARITY_MSG_ERROR_O(par_err),
		.TERMINAL_FLAG_BIT_O(tf_bit), .SUBSYSTEM_BUSY_BIT_O(subsystem_busy_bit_bit),
		.SERVICE_REQUEST_BIT_O(srv_bit), .LAST_CMD_O(last_cmd));

	// Count cycles with the reset pulse high
	always @(negedge clk) begin
		if (mreset === 1'b1) begin
			mr_cnt++;
		end
	end

	// Compare and count
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			err_count++;
		end
	endtask

	// Closing report
	task automatic print_verdict();
		$display("mismatches %0d, checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Status read through the host model
	task automatic rd(input logic a0);
		u_rthri_host_model.read(a0, rd_val, rd_oe);
	endtask

	// Command strobe low for one cycle, flags settle after
	task automatic strobe();
		@(negedge clk);
		strobe_n = 1'b0;
		@(negedge clk);
		strobe_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask

	// Stored command from the core
	task automatic cmd(input logic [15:0] w, input logic a, input logic il);
		@(negedge clk);
		cmd_word = w;
		cmd_a = a;
		cmd_ill = il;
		cmd_store = 1'b1;
		@(negedge clk);
		cmd_store = 1'b0;
		@(negedge clk);
	endtask

	// Terminal address reload
	task automatic ta_reload(input logic ok);
		@(negedge clk);
		ta_ok = ok;
		ta_load = 1'b1;
		@(negedge clk);
		ta_load = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		print_verdict();
	end

	// Main sequence
	initial begin
		rows = '{{16'h0001, 16'h0340, 5'h10},
			{16'h0002, 16'h02C0, 5'h08},
			{16'h0008, 16'h0640, 5'h04},
			{16'h0060, 16'h0A40, 5'h03},
			{16'h0043, 16'h0BC0, 5'h02},
			{16'h00FF, 16'h0FC0, 5'h07},
			{16'hFF00, 16'h0240, 5'h00}};
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		rd(1'b0);
		check("reset status", rd_val, 16'h0240);
		check("read drive", {15'h0, rd_oe}, 16'h0001);
		check("reset last", last_cmd, LAST_CMD_RESET);
		// Control byte to status bits and core controls
		for (int i = 0; i < 7; i++) begin
			u_rthri_host_model.write(1'b0, rows[i][36:21]);
			@(negedge clk);
			check("controls", {11'h0, cha_en, chb_en, mem_inh, st_en, st_ch},
				{11'h0, rows[i][4:0]});
			rd(1'b0);
			check("status", rd_val, rows[i][20:5]);
		end
		// Flags reach the status word at the strobe
		u_rthri_host_model.write(1'b0, 16'h0094);
		repeat (CTRL_SETUP_CYC) @(negedge clk);
		strobe();
		check("flags", {13'h0, tf_bit, subsystem_busy_bit_bit, srv_bit}, 16'h0007);
		@(negedge clk);
		inh_tf = 1'b1;
		@(negedge clk);
		inh_tf = 1'b0;
		strobe();
		check("inhibited", {13'h0, tf_bit, subsystem_busy_bit_bit, srv_bit}, 16'h0003);
		rd(1'b0);
		check("tf off", rd_val, 16'h0040);
		@(negedge clk);
		ovr_tf = 1'b1;
		@(negedge clk);
		ovr_tf = 1'b0;
		rd(1'b1);
		check("odd read", {15'h0, rd_oe}, 16'h0000);
		// Command decode and last command
		cmd(16'h0065, 1'b1, 1'b0);
		check("last sa", last_cmd, 16'h6065);
		rd(1'b0);
		check("sa decode", rd_val, 16'h0263);
		cmd(16'h0406, 1'b1, 1'b1);
		check("last mc", last_cmd, 16'hE406);
		rd(1'b0);
		check("mc decode", rd_val, 16'h0246);
		cmd(16'h03E2, 1'b1, 1'b0);
		rd(1'b0);
		check("mc high", rd_val, 16'h0242);
		cmd(16'h0065, 1'b0, 1'b0);
		rd(1'b0);
		check("chan b", rd_val, 16'h0223);
		// Sticky valid and error bits
		@(negedge clk);
		valid_msg = 1'b1;
		@(negedge clk);
		valid_msg = 1'b0;
		rd(1'b0);
		check("valid set", rd_val & 16'h4000, 16'h4000);
		rd(1'b0);
		check("valid clr", rd_val & 16'h4000, 16'h0000);
		msg_err = 1'b1;
		rd(1'b0);
		rd(1'b0);
		check("err held", rd_val & 16'h2000, 16'h2000);
		msg_err = 1'b0;
		repeat (3) @(negedge clk);
		rd(1'b0);
		check("err clr", rd_val & 16'h2000, 16'h0000);
		// Address parity error
		u_rthri_host_model.write(1'b0, 16'h0003);
		ta_reload(1'b0);
		check("parity", {14'h0, par_err, cha_en}, 16'h0002);
		rd(1'b0);
		check("parity st", rd_val & 16'h1000, 16'h1000);
		ta_reload(1'b1);
		check("parity clr", {14'h0, par_err, cha_en}, 16'h0001);
		// Terminal activity
		tx_n = 1'b0;
		rd(1'b0);
		check("tx active", rd_val & 16'h8000, 16'h8000);
		tx_n = 1'b1;
		rx_n = 1'b0;
		rd(1'b0);
		check("rx active", rd_val & 16'h8000, 16'h8000);
		rx_n = 1'b1;
		// Master reset by write with address bit high
		u_rthri_host_model.write(1'b1, 16'h00FF);
		repeat (3) @(negedge clk);
		check("mreset", mr_cnt[15:0], 16'h0001);
		check("ch after", {15'h0, cha_en}, 16'h0000);
		rd(1'b0);
		check("mr status", rd_val, 16'h0240);
		print_verdict();
	end
endmodule
